// ---- src/host_serial_port_pkg.sv ----
// Constants, encodings and timing counts shared by the host serial port pin control.
package host_serial_port_pkg;

    // ==========================================================
    // Word and buffer geometry
    localparam int WORD_BITS = 8;
    localparam int BUF_DEPTH = 2;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST  = 3'h7;

    // ==========================================================
    // Timing: master serial clock half period
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_HALF_NS   = 500;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W         = 4;
    localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);

    // ==========================================================
    // General-purpose direction of the request pin
    localparam logic [1:0] GPIO_DISC = 2'h0;
    localparam logic [1:0] GPIO_IN   = 2'h1;
    localparam logic [1:0] GPIO_OUT  = 2'h2;

    // ==========================================================
    // Reset values
    localparam logic [1:0] SYNC_HIGH = 2'h3;
    localparam logic [1:0] SYNC_LOW  = 2'h0;

    // ==========================================================
    // Master word sequencer
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW  = 2'b01,
        M_HIGH = 2'b10
    } master_state_e;

endpackage

// ---- src/word_buffer.sv ----
// Small valid/ready buffer that holds received words until the user takes them.
`timescale 1ns/1ps
module word_buffer #(
    parameter int WIDTH = host_serial_port_pkg::WORD_BITS,
    parameter int DEPTH = host_serial_port_pkg::BUF_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } buf_s;

    buf_s st;
    buf_s next_st;
    logic push;
    logic pop;

    assign in_ready  = st.count != (PW + 1)'(DEPTH);
    assign out_valid = st.count != '0;
    assign out_data  = st.mem[st.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10:   next_st.count = st.count + 1'b1;
            2'b01:   next_st.count = st.count - 1'b1;
            default: next_st.count = st.count;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule // word_buffer

// ---- src/host_serial_port.sv ----
// Pin control of the host serial port: data line, slave select, address straps and request line.
`timescale 1ns/1ps
module host_serial_port (
    // Clock and reset
    input  wire logic                                     clk_sys,
    input  wire logic                                     rst,
    input  wire logic                                     port_reset,
    // Configuration
    input  wire logic                                     i2c_mode,
    input  wire logic                                     master_mode,
    input  wire logic                                     req_gpio_en,
    input  wire logic [1:0]                               gpio_dir,
    input  wire logic                                     gpio_out,
    output logic                                          gpio_in,
    // Status
    output logic                                          bus_error,
    input  wire logic                                     bus_error_clr,
    output logic [1:0]                                    own_addr_bits,
    // Serial clock pins
    input  wire logic                                     sck_in,
    output logic                                          sck_out,
    output logic                                          sck_oe,
    // Data and select pins
    input  wire logic                                     mosi_in,
    output logic                                          mosi_out,
    output logic                                          mosi_oe,
    output logic                                          miso_oe,
    input  wire logic                                     ss_n_in,
    // Address strap pins
    input  wire logic                                     i2c_addr_strap_bit0,
    input  wire logic                                     i2c_addr_strap_bit2,
    // Request pin
    input  wire logic                                     host_request_n_in,
    output logic                                          host_request_n_out,
    output logic                                          host_request_n_oe,
    // Transmit words for master mode
    input  wire logic                                     tx_valid,
    output logic                                          tx_ready,
    input  wire logic [host_serial_port_pkg::WORD_BITS-1:0] tx_data,
    // Received words in slave mode
    output logic                                          rx_valid,
    input  wire logic                                     rx_ready,
    output logic [host_serial_port_pkg::WORD_BITS-1:0]    rx_data
);
    localparam int W = host_serial_port_pkg::WORD_BITS;

    typedef struct packed {
        logic [1:0]                                  ss_sync;
        logic [1:0]                                  req_sync;
        logic [1:0]                                  a0_sync;
        logic [1:0]                                  a2_sync;
        logic [1:0]                                  sck_sync;
        logic [1:0]                                  mosi_sync;
        logic                                        sck_prev;
        logic                                        bus_error;
        logic [1:0]                                  strap;
        logic                                        gpio_in;
        logic [W-1:0]                                rx_shift;
        logic [host_serial_port_pkg::BIT_CNT_W-1:0]  rx_cnt;
        logic                                        in_word;
        logic                                        push;
        logic                                        req_n;
        logic                                        armed;
        host_serial_port_pkg::master_state_e         mstate;
        logic [host_serial_port_pkg::DIV_W-1:0]      div;
        logic [W-1:0]                                tx_shift;
        logic [host_serial_port_pkg::BIT_CNT_W-1:0]  tx_cnt;
        logic                                        sck_out;
        logic                                        mosi_out;
    } port_s;

    // Select and request idle high so that no false bus error or request follows reset.
    localparam port_s ST_RESET = '{
        ss_sync:  host_serial_port_pkg::SYNC_HIGH,
        req_sync: host_serial_port_pkg::SYNC_HIGH,
        a0_sync:  host_serial_port_pkg::SYNC_LOW,
        a2_sync:  host_serial_port_pkg::SYNC_LOW,
        sck_sync: host_serial_port_pkg::SYNC_LOW,
        mosi_sync: host_serial_port_pkg::SYNC_LOW,
        req_n:    1'b1,
        mstate:   host_serial_port_pkg::M_IDLE,
        default:  '0
    };

    port_s st;
    port_s next_st;
    logic  spi_master;
    logic  spi_slave;
    logic  ss_active;
    logic  req_active;
    logic  sck_rise;
    logic  clock_taken;
    logic  tick;
    logic  master_go;
    logic  buf_in_ready;

    // ==========================================================
    // Mode decode and pin functions
    // The data, clock and MISO pins float under the asynchronous reset as well as under the port reset; the request pin floats only under the port reset.
    assign spi_master  = !rst && !port_reset && !i2c_mode && master_mode;
    assign spi_slave   = !rst && !port_reset && !i2c_mode && !master_mode;
    assign ss_active   = !st.ss_sync[1];
    assign req_active  = !st.req_sync[1];
    assign sck_rise    = st.sck_sync[1] && !st.sck_prev;
    assign clock_taken = sck_rise && (i2c_mode || (spi_slave && ss_active));
    assign tick        = st.div == host_serial_port_pkg::DIV_LAST;
    assign master_go   = spi_master && tx_valid && !ss_active && st.mstate == host_serial_port_pkg::M_IDLE
                         && (req_gpio_en || (st.armed && req_active));

    assign mosi_oe  = spi_master;
    assign mosi_out = st.mosi_out;
    assign sck_oe   = spi_master;
    assign sck_out  = st.sck_out;
    assign miso_oe  = spi_slave && ss_active;
    assign tx_ready = master_go;

    assign host_request_n_oe  = port_reset ? 1'b0 : req_gpio_en ? (gpio_dir == host_serial_port_pkg::GPIO_OUT)
                                : !master_mode;
    assign host_request_n_out = req_gpio_en ? gpio_out : st.req_n;
    assign bus_error          = st.bus_error;
    assign own_addr_bits      = st.strap;
    assign gpio_in            = st.gpio_in;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.push = 1'b0;
        // Only the second stage of each synchroniser is read by the logic.
        next_st.ss_sync   = {st.ss_sync[0], ss_n_in};
        next_st.req_sync  = {st.req_sync[0], host_request_n_in};
        next_st.a0_sync   = {st.a0_sync[0], i2c_addr_strap_bit0};
        next_st.a2_sync   = {st.a2_sync[0], i2c_addr_strap_bit2};
        next_st.sck_sync  = {st.sck_sync[0], sck_in};
        next_st.mosi_sync = {st.mosi_sync[0], mosi_in};
        next_st.sck_prev  = st.sck_sync[1];

        next_st.strap   = (i2c_mode && !master_mode) ? {st.a2_sync[1], st.a0_sync[1]} : 2'b00;
        next_st.gpio_in = req_gpio_en && gpio_dir == host_serial_port_pkg::GPIO_IN && st.req_sync[1];

        // Set wins over a simultaneous clear.
        if (bus_error_clr) begin
            next_st.bus_error = 1'b0;
        end
        if (spi_master && ss_active) begin
            next_st.bus_error = 1'b1;
        end

        // Slave side: word counting, reception and request line.
        if (master_mode || (spi_slave && !ss_active)) begin
            next_st.in_word = 1'b0;
            next_st.rx_cnt  = host_serial_port_pkg::BIT_FIRST;
            // A deselected slave still asks for the next word, or a paced master would wait forever.
            next_st.req_n   = master_mode || st.push || !buf_in_ready;
        end else if (clock_taken) begin
            next_st.in_word = 1'b1;
            next_st.req_n   = 1'b1;
            if (spi_slave) begin
                next_st.rx_shift = {st.rx_shift[W-2:0], st.mosi_sync[1]};
            end
            if (st.rx_cnt == host_serial_port_pkg::BIT_LAST) begin
                next_st.in_word = 1'b0;
                next_st.push    = spi_slave;
                next_st.rx_cnt  = host_serial_port_pkg::BIT_FIRST;
            end else begin
                next_st.rx_cnt = st.rx_cnt + 1'b1;
            end
        end else if (!st.in_word && !st.push && buf_in_ready) begin
            next_st.req_n = 1'b0;
        end

        // Master side: a fresh request is one seen low after having been high.
        if (st.req_sync[1]) begin
            next_st.armed = 1'b1;
        end
        next_st.div = (st.mstate == host_serial_port_pkg::M_IDLE || tick) ? host_serial_port_pkg::DIV_ZERO
                      : st.div + 1'b1;
        case (st.mstate)
            host_serial_port_pkg::M_IDLE: begin
                next_st.sck_out = 1'b0;
                if (master_go) begin
                    next_st.armed    = 1'b0;
                    next_st.tx_shift = tx_data;
                    next_st.tx_cnt   = host_serial_port_pkg::BIT_FIRST;
                    next_st.mosi_out = tx_data[W-1];
                    next_st.mstate   = host_serial_port_pkg::M_LOW;
                end
            end
            host_serial_port_pkg::M_LOW: begin
                if (tick) begin
                    next_st.sck_out = 1'b1;
                    next_st.mstate  = host_serial_port_pkg::M_HIGH;
                end
            end
            host_serial_port_pkg::M_HIGH: begin
                if (tick) begin
                    next_st.sck_out  = 1'b0;
                    next_st.tx_shift = {st.tx_shift[W-2:0], 1'b0};
                    next_st.mosi_out = st.tx_shift[W-2];
                    next_st.tx_cnt   = st.tx_cnt + 1'b1;
                    next_st.mstate   = (st.tx_cnt == host_serial_port_pkg::BIT_LAST)
                                       ? host_serial_port_pkg::M_IDLE : host_serial_port_pkg::M_LOW;
                end
            end
            default: begin
                next_st.mstate = host_serial_port_pkg::M_IDLE;
            end
        endcase
        // A select fault or a change out of master mode abandons the word in flight.
        if (!spi_master || ss_active) begin
            next_st.mstate  = host_serial_port_pkg::M_IDLE;
            next_st.sck_out = 1'b0;
        end

        if (port_reset) begin
            next_st = ST_RESET;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Receive buffer
    // The request line is held off while the buffer is full, so a stall never drops a word.
    word_buffer #(
        .WIDTH (W),
        .DEPTH (host_serial_port_pkg::BUF_DEPTH)
    ) u_rx_buffer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (st.push),
        .in_ready  (buf_in_ready),
        .in_data   (st.rx_shift),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_mosi_reset_undriven;
        port_reset |-> !mosi_oe ##1 (st.mstate == host_serial_port_pkg::M_IDLE);
    endproperty
    a_mosi_reset_undriven: assert property (p_mosi_reset_undriven) else $error("MOSI driven during port reset");

    property p_master_drives_mosi;
        spi_master |-> mosi_oe && !miso_oe;
    endproperty
    a_master_drives_mosi: assert property (p_master_drives_mosi) else $error("SPI master not driving MOSI");

    property p_slave_listens_mosi;
        !master_mode |-> !mosi_oe && !sck_oe;
    endproperty
    a_slave_listens_mosi: assert property (p_slave_listens_mosi) else $error("slave drives MOSI");

    property p_miso_hiz_deselected;
        (spi_slave && ss_n_in) ##1 (spi_slave && ss_n_in) ##1 spi_slave |-> !miso_oe;
    endproperty
    a_miso_hiz_deselected: assert property (p_miso_hiz_deselected) else $error("MISO driven while deselected");

    property p_bus_error_set;
        (spi_master && !ss_n_in) ##1 spi_master [*2] |=> bus_error;
    endproperty
    a_bus_error_set: assert property (p_bus_error_set) else $error("bus error not flagged");

    property p_req_drop_first_clock;
        (!req_gpio_en && $rose(st.in_word)) |-> host_request_n_out;
    endproperty
    a_req_drop_first_clock: assert property (p_req_drop_first_clock) else $error("request held into word");

    property p_master_needs_request;
        (tx_ready && !req_gpio_en) |-> !st.req_sync[1] && st.armed;
    endproperty
    a_master_needs_request: assert property (p_master_needs_request) else $error("word started without request");

    property p_fresh_request;
        (tx_ready && !req_gpio_en) |=> !st.armed;
    endproperty
    a_fresh_request: assert property (p_fresh_request) else $error("request reused for next word");

    property p_strap_slave_address;
        (i2c_mode && !master_mode && !port_reset) [*4]
            |-> own_addr_bits == {$past(i2c_addr_strap_bit2, 3), $past(i2c_addr_strap_bit0, 3)};
    endproperty
    a_strap_slave_address: assert property (p_strap_slave_address) else $error("strap address mismatch");

    property p_strap_master_ignored;
        (i2c_mode && master_mode) |=> own_addr_bits == 2'b00;
    endproperty
    a_strap_master_ignored: assert property (p_strap_master_ignored) else $error("strap used as master");

    property p_gpio_disconnected;
        (req_gpio_en && gpio_dir == host_serial_port_pkg::GPIO_DISC) |-> !host_request_n_oe ##1 !gpio_in;
    endproperty
    a_gpio_disconnected: assert property (p_gpio_disconnected) else $error("disconnected GPIO active");

    c_master_word: cover property (st.mstate == host_serial_port_pkg::M_HIGH ##1 st.mstate == host_serial_port_pkg::M_IDLE);
    c_slave_push: cover property (st.push);
    c_bus_error: cover property ($rose(bus_error));
    c_buffer_full: cover property (!buf_in_ready && !rx_ready);

endmodule // host_serial_port

// ---- tb/spi_slave_model.sv ----
// Behavioural external SPI slave that paces the port's master transfers through the request line.
`timescale 1ns/1ps
module spi_slave_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            req_n,
    // Bench control and capture
    input  wire logic       ready,
    output logic [7:0]      word,
    output logic            word_done
);
    logic       sck_q;
    logic [2:0] count;

    // ==========================================================
    // Capture and request pacing
    // The request is lowered only while the bench says ready, so the bench can act as a slow slave.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sck_q     <= 1'b0;
            count     <= 3'h0;
            req_n     <= 1'b1;
            word      <= 8'h00;
            word_done <= 1'b0;
        end else begin
            sck_q     <= sck;
            word_done <= 1'b0;
            if (sck && !sck_q) begin
                word  <= {word[6:0], mosi};
                req_n <= 1'b1;
                count <= count + 3'h1;
                word_done <= (count == 3'h7);
            end else if (count == 3'h0 && ready) begin
                req_n <= 1'b0;
            end
        end
    end
endmodule // spi_slave_model

// ---- tb/testbench.sv ----
// Self-checking testbench of the host serial port pin control.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0, rst = 1'b1, port_reset = 1'b0, i2c_mode = 1'b0, master_mode = 1'b1;
    logic req_gpio_en = 1'b0, gpio_out = 1'b0, bus_error_clr = 1'b0, sck_in = 1'b0, mosi_in = 1'b0;
    logic ss_n_in = 1'b1, i2c_addr_strap_bit0 = 1'b0, i2c_addr_strap_bit2 = 1'b0, tx_valid = 1'b0;
    logic rx_ready = 1'b0, ready = 1'b0, gpio_drv = 1'b1, req_hold = 1'b0;
    logic [1:0] gpio_dir = host_serial_port_pkg::GPIO_DISC;
    logic [7:0] tx_data = 8'h00;
    logic gpio_in, bus_error, sck_out, sck_oe, mosi_out, mosi_oe, miso_oe, host_request_n_out;
    logic host_request_n_oe, tx_ready, rx_valid, part_req_n, part_done, req_pin;
    logic [1:0] own_addr_bits;
    logic [7:0] rx_data, part_word, w0, w1;
    int num_errors = 0, comparisons = 0;

    // The request pin has a pull-up, so nobody driving it reads high.
    // The bench may hold it low to play a slave that never releases its request.
    assign req_pin = host_request_n_oe ? host_request_n_out : (req_gpio_en ? gpio_drv :
                     (master_mode ? (part_req_n && !req_hold) : 1'b1));

    always #50 clk_sys = ~clk_sys;

    host_serial_port dut_u (.clk_sys, .rst, .port_reset, .i2c_mode, .master_mode, .req_gpio_en, .gpio_dir,
        .gpio_out, .gpio_in, .bus_error, .bus_error_clr, .own_addr_bits, .sck_in, .sck_out, .sck_oe, .mosi_in,
        .mosi_out, .mosi_oe, .miso_oe, .ss_n_in, .i2c_addr_strap_bit0, .i2c_addr_strap_bit2,
        .host_request_n_in(req_pin), .host_request_n_out, .host_request_n_oe, .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_ready, .rx_data);

    spi_slave_model part_u (.clk_sys(clk_sys), .rst(rst), .sck(sck_out), .mosi(mosi_out), .req_n(part_req_n),
        .ready(ready), .word(part_word), .word_done(part_done));

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic final_report();
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The bench stalls as a slow slave first, so no word may start without a fresh request.
    task automatic send_master(input logic [7:0] d, input int stall, input logic hold);
        logic seen;
        int n;
        seen = 1'b0;
        n = 0;
        tx_valid = 1'b1;
        tx_data = d;
        repeat (stall) begin
            cyc(1);
            seen |= tx_ready;
        end
        check("tx_ready_stalled", {7'h0, seen}, 8'h00);
        req_hold = hold;
        ready = 1'b1;
        while (tx_ready !== 1'b1 && n < 50) begin cyc(1); n++; end
        check("tx_ready", {7'h0, tx_ready}, 8'h01);
        cyc(1);
        tx_valid = 1'b0;
        ready = 1'b0;
        n = 0;
        while (part_done !== 1'b1 && n < 120) begin cyc(1); n++; end
        check("master_done", {7'h0, part_done}, 8'h01);
        check("master_word", part_word, d);
    endtask

    task automatic slave_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            mosi_in = d[i];
            cyc(3);
            sck_in = 1'b1;
            cyc(3);
            sck_in = 1'b0;
            if (i == 5) check("request_after_clock", {7'h0, host_request_n_out}, {7'h0, !ss_n_in});
        end
        cyc(6);
    endtask

    task automatic take_word(input logic [7:0] exp);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 20) begin cyc(1); n++; end
        check("slave_valid", {7'h0, rx_valid}, 8'h01);
        check("slave_word", rx_data, exp);
        cyc(1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(10943));
        cyc(3);
        check("oe_in_reset", {5'h0, mosi_oe, sck_oe, miso_oe}, 8'h00);
        cyc(1);
        rst = 1'b0;
        cyc(3);
        send_master(8'h00, 0, 1'b1);
        send_master(8'hFF, 30, 1'b0);
        send_master(8'hA5, 5, 1'b0);
        send_master(8'($urandom), 12, 1'b0);
        ss_n_in = 1'b0;
        cyc(4);
        check("bus_error_set", {6'h0, bus_error, tx_ready}, 8'h02);
        ss_n_in = 1'b1;
        cyc(3);
        bus_error_clr = 1'b1;
        cyc(1);
        bus_error_clr = 1'b0;
        cyc(1);
        check("bus_error_clear", {7'h0, bus_error}, 8'h00);
        master_mode = 1'b0;
        cyc(4);
        check("slave_request", {6'h0, host_request_n_oe, host_request_n_out}, 8'h02);
        ss_n_in = 1'b0;
        cyc(3);
        check("miso_oe_selected", {6'h0, miso_oe, mosi_oe}, 8'h02);
        w0 = 8'($urandom);
        w1 = 8'h81;
        slave_byte(w0);
        check("request_ready_again", {7'h0, host_request_n_out}, 8'h00);
        slave_byte(w1);
        check("request_buffer_full", {7'h0, host_request_n_out}, 8'h01);
        rx_ready = 1'b1;
        take_word(w0);
        take_word(w1);
        rx_ready = 1'b0;
        ss_n_in = 1'b1;
        cyc(3);
        check("miso_oe_deselected", {7'h0, miso_oe}, 8'h00);
        slave_byte(8'($urandom));
        check("ignored_clocks", {7'h0, rx_valid}, 8'h00);
        i2c_mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {i2c_addr_strap_bit2, i2c_addr_strap_bit0} = 2'(k);
            cyc(4);
            check("own_addr_slave", {6'h0, own_addr_bits}, 8'(k));
        end
        master_mode = 1'b1;
        cyc(4);
        check("own_addr_master", {5'h0, own_addr_bits, mosi_oe}, 8'h00);
        i2c_mode = 1'b0;
        req_gpio_en = 1'b1;
        gpio_dir = host_serial_port_pkg::GPIO_OUT;
        gpio_out = 1'($urandom);
        cyc(2);
        check("gpio_output", {6'h0, host_request_n_oe, host_request_n_out}, {6'h0, 1'b1, gpio_out});
        gpio_dir = host_serial_port_pkg::GPIO_IN;
        gpio_drv = 1'b0;
        cyc(4);
        check("gpio_input", {6'h0, host_request_n_oe, gpio_in}, 8'h00);
        gpio_drv = 1'b1;
        cyc(4);
        check("gpio_input_high", {7'h0, gpio_in}, 8'h01);
        gpio_dir = host_serial_port_pkg::GPIO_DISC;
        cyc(4);
        check("gpio_disconnected", {6'h0, host_request_n_oe, gpio_in}, 8'h00);
        port_reset = 1'b1;
        cyc(2);
        check("oe_port_reset", {6'h0, mosi_oe, sck_oe}, 8'h00);
        port_reset = 1'b0;
        cyc(1);
        check("oe_master", {6'h0, mosi_oe, sck_oe}, 8'h03);
        final_report();
    end

    // A full run takes well under a thousand cycles; the watchdog allows 20000 cycles, over twenty times that.
    initial begin
        #2_000_000;
        num_errors++;
        final_report();
    end
endmodule // testbench
